/* inc/vip_pkg.sv */
// ----------------------------------------------------------------
// vectored interrupt prioritizer constants
// ----------------------------------------------------------------
package vip_pkg;

    // sizes
    localparam int NUM_REQ = 24;
    localparam int LVL_W = 2;
    localparam int NUM_W = 5;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int LVL_REGS = 6;
    localparam int EN_REGS = 3;

    // register offsets
    localparam logic [3:0] OFS_LVL0 = 4'h0;
    localparam logic [3:0] OFS_EN0 = 4'h6;
    localparam logic [3:0] OFS_EXT_PEND = 4'h9;
    localparam logic [3:0] OFS_STAT = 4'hA;
    localparam logic [3:0] OFS_EXT_CFG = 4'hB;

    // field positions
    localparam int EXT_CH4_BIT = 0;
    localparam int EXT_CH6_BIT = 1;

    // reset values
    localparam logic [7:0] LVL_RST = 8'hFF;
    localparam logic [7:0] EN_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;

    // request numbers of the wired sources
    localparam logic [4:0] SRC_EXT4 = 5'h00;
    localparam logic [4:0] SRC_EXT6 = 5'h02;
    localparam logic [4:0] SRC_TMR0_LO = 5'h05;
    localparam logic [4:0] SRC_TMR0_HI = 5'h06;
    localparam logic [4:0] SRC_ADC = 5'h12;
    localparam logic [4:0] SRC_TBT = 5'h13;
    localparam logic [4:0] SRC_WPRE = 5'h14;
    localparam logic [4:0] SRC_FLASH = 5'h17;

    // vector table: request 0 upper byte, two bytes per request downward
    localparam logic [15:0] VEC_TOP = 16'hFFFA;
    localparam logic [15:0] VEC_LO_OFS = 16'h0001;

    // least pin phase the far side must hold, in machine clocks
    localparam int PULSE_MIN_CLK = 2;

endpackage

/* rtl/vip_pick.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// level-then-number arbiter, purely combinational
// ----------------------------------------------------------------
module vip_pick #(
    parameter int N = 24,
    parameter int NW = 5
) (
    // requests and their levels
    input wire logic [N-1:0] req,
    input wire logic [2*N-1:0] lvl,
    // winner
    output logic found,
    output logic [NW-1:0] num,
    output logic [1:0] level
);

    // scan from the top down so a tie at equal level falls to the lower number
    always_comb
    begin
        found = 1'b0;
        num = '0;
        level = 2'h3;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req[i] && (!found || lvl[2*i +: 2] <= level))
            begin
                found = 1'b1;
                num = NW'(i);
                level = lvl[2*i +: 2];
            end
        end
    end

endmodule // vip_pick

/* rtl/vip_top.sv */
`timescale 1ns/1ps
module vip_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // external interrupt pins
    input wire logic ext_irq_in_ch4,
    input wire logic ext_irq_in_ch6,
    // peripheral request levels
    input wire logic tmr0_lo_req,
    input wire logic tmr0_hi_req,
    input wire logic adc_req,
    input wire logic tbt_req,
    input wire logic wpre_req,
    input wire logic flash_req,
    // core side
    input wire logic irq_ack,
    output logic irq_valid,
    output logic [4:0] irq_num,
    output logic [1:0] irq_level,
    output logic [15:0] vec_hi_addr,
    output logic [15:0] vec_lo_addr
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0] lvl_reg [0:vip_pkg::LVL_REGS-1];
    logic [7:0] lvl_next [0:vip_pkg::LVL_REGS-1];
    logic [7:0] en_reg [0:vip_pkg::EN_REGS-1];
    logic [7:0] en_next [0:vip_pkg::EN_REGS-1];
    logic [1:0] cfg_reg;
    logic [1:0] cfg_next;
    logic [1:0] pend_reg;
    logic [1:0] pend_next;
    logic [1:0] pin_reg;
    logic [1:0] pin_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic valid_reg;
    logic valid_next;
    logic [4:0] num_reg;
    logic [4:0] num_next;
    logic [1:0] level_reg;
    logic [1:0] level_next;
    logic [15:0] vhi_reg;
    logic [15:0] vhi_next;
    logic [15:0] vlo_reg;
    logic [15:0] vlo_next;
    logic [1:0] pin_now;
    logic [1:0] edge_seen;
    logic [vip_pkg::NUM_REQ-1:0] raw_req;
    logic [vip_pkg::NUM_REQ-1:0] en_flat;
    logic [2*vip_pkg::NUM_REQ-1:0] lvl_flat;
    logic pick_found;
    logic [4:0] pick_num;
    logic [1:0] pick_level;
    logic ack_taken;

    // ----------------------------------------------------------------
    // external pin edge detection
    // ----------------------------------------------------------------
    // pins are synchronous; one stored sample is enough because the far side
    // holds each phase for two clocks, so no edge can slip between samples
    assign pin_now = {ext_irq_in_ch6, ext_irq_in_ch4};

    always_comb
    begin
        pin_next = pin_now;
        for (int i = 0; i < 2; i++)
        begin
            // cfg bit set selects the falling edge, clear the rising edge
            if (cfg_reg[i])
                edge_seen[i] = pin_reg[i] && !pin_now[i];
            else
                edge_seen[i] = !pin_reg[i] && pin_now[i];
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            pin_reg <= 2'h0;
        else
            pin_reg <= pin_next;
    end

    // ----------------------------------------------------------------
    // external pending flags
    // ----------------------------------------------------------------
    // the core's acknowledge of the current winner clears its flag
    assign ack_taken = irq_ack && valid_reg;

    // cleared by write-one or by acknowledge; a new edge in the same cycle wins
    always_comb
    begin
        pend_next = pend_reg;
        if (reg_wr && reg_addr == vip_pkg::OFS_EXT_PEND)
            pend_next = pend_next & ~reg_wdata[1:0];
        if (ack_taken && num_reg == vip_pkg::SRC_EXT4)
            pend_next[vip_pkg::EXT_CH4_BIT] = 1'b0;
        if (ack_taken && num_reg == vip_pkg::SRC_EXT6)
            pend_next[vip_pkg::EXT_CH6_BIT] = 1'b0;
        pend_next = pend_next | edge_seen;
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            pend_reg <= 2'h0;
        else
            pend_reg <= pend_next;
    end

    // ----------------------------------------------------------------
    // request routing to fixed numbers
    // ----------------------------------------------------------------
    // numbers with no source stay quiet
    always_comb
    begin
        raw_req = '0;
        raw_req[vip_pkg::SRC_EXT4] = pend_reg[vip_pkg::EXT_CH4_BIT];
        raw_req[vip_pkg::SRC_EXT6] = pend_reg[vip_pkg::EXT_CH6_BIT];
        raw_req[vip_pkg::SRC_TMR0_LO] = tmr0_lo_req;
        raw_req[vip_pkg::SRC_TMR0_HI] = tmr0_hi_req;
        raw_req[vip_pkg::SRC_ADC] = adc_req;
        raw_req[vip_pkg::SRC_TBT] = tbt_req;
        raw_req[vip_pkg::SRC_WPRE] = wpre_req;
        raw_req[vip_pkg::SRC_FLASH] = flash_req;
    end

    // flatten level and enable registers, four levels to a byte
    always_comb
    begin
        for (int i = 0; i < vip_pkg::LVL_REGS; i++)
            lvl_flat[8*i +: 8] = lvl_reg[i];
        for (int i = 0; i < vip_pkg::EN_REGS; i++)
            en_flat[8*i +: 8] = en_reg[i];
    end

    // ----------------------------------------------------------------
    // arbitration
    // ----------------------------------------------------------------
    vip_pick #(
        .N(vip_pkg::NUM_REQ),
        .NW(vip_pkg::NUM_W)
    ) u_pick (
        .req(raw_req & en_flat),
        .lvl(lvl_flat),
        .found(pick_found),
        .num(pick_num),
        .level(pick_level)
    );

    // winner and its vector pair, held in flops for the core
    always_comb
    begin
        valid_next = pick_found;
        num_next = pick_num;
        level_next = pick_level;
        vhi_next = 16'(vip_pkg::VEC_TOP - {10'h000, pick_num, 1'b0});
        vlo_next = 16'(vhi_next + vip_pkg::VEC_LO_OFS);
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            valid_reg <= 1'b0;
            num_reg <= 5'h00;
            level_reg <= 2'h0;
            vhi_reg <= 16'h0000;
            vlo_reg <= 16'h0000;
        end
        else
        begin
            valid_reg <= valid_next;
            num_reg <= num_next;
            level_reg <= level_next;
            vhi_reg <= vhi_next;
            vlo_reg <= vlo_next;
        end
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // level, enable and edge select registers written by software
    always_comb
    begin
        for (int i = 0; i < vip_pkg::LVL_REGS; i++)
        begin
            lvl_next[i] = lvl_reg[i];
            if (reg_wr && reg_addr == 4'(vip_pkg::OFS_LVL0 + 4'(i)))
                lvl_next[i] = reg_wdata;
        end
        for (int i = 0; i < vip_pkg::EN_REGS; i++)
        begin
            en_next[i] = en_reg[i];
            if (reg_wr && reg_addr == 4'(vip_pkg::OFS_EN0 + 4'(i)))
                en_next[i] = reg_wdata;
        end
        cfg_next = cfg_reg;
        if (reg_wr && reg_addr == vip_pkg::OFS_EXT_CFG)
            cfg_next = reg_wdata[1:0];
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < vip_pkg::LVL_REGS; i++)
                lvl_reg[i] <= vip_pkg::LVL_RST;
            for (int i = 0; i < vip_pkg::EN_REGS; i++)
                en_reg[i] <= vip_pkg::EN_RST;
            cfg_reg <= vip_pkg::CFG_RST[1:0];
        end
        else
        begin
            for (int i = 0; i < vip_pkg::LVL_REGS; i++)
                lvl_reg[i] <= lvl_next[i];
            for (int i = 0; i < vip_pkg::EN_REGS; i++)
                en_reg[i] <= en_next[i];
            cfg_reg <= cfg_next;
        end
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    always_comb
    begin
        rdata_next = 8'h00;
        if (reg_rd)
        begin
            if (reg_addr < vip_pkg::OFS_EN0)
                rdata_next = lvl_reg[3'(reg_addr)];
            else if (reg_addr < vip_pkg::OFS_EXT_PEND)
                rdata_next = en_reg[2'(reg_addr - vip_pkg::OFS_EN0)];
            else if (reg_addr == vip_pkg::OFS_EXT_PEND)
                rdata_next = {6'h00, pend_reg};
            else if (reg_addr == vip_pkg::OFS_STAT)
                rdata_next = {valid_reg, level_reg, num_reg};
            else if (reg_addr == vip_pkg::OFS_EXT_CFG)
                rdata_next = {6'h00, cfg_reg};
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = rdata_reg;
    assign irq_valid = valid_reg;
    assign irq_num = num_reg;
    assign irq_level = level_reg;
    assign vec_hi_addr = vhi_reg;
    assign vec_lo_addr = vlo_reg;

endmodule // vip_top

/* dv/vip_props.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checks for the prioritizer
// ----------------------------------------------------------------
module vip_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // sources and core side
    input wire logic tmr0_lo_req,
    input wire logic tmr0_hi_req,
    input wire logic irq_valid,
    input wire logic [4:0] irq_num,
    input wire logic [1:0] irq_level,
    input wire logic [15:0] vec_hi_addr,
    input wire logic [15:0] vec_lo_addr
);
    // one domain, so clock and reset are given once
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // vector table and source wiring
    vec_pair_a: assert property (irq_valid |-> vec_lo_addr == vec_hi_addr + 16'h0001)
        else $error("vector lower address wrong");
    vec_table_a: assert property (irq_valid |-> vec_hi_addr == 16'hFFFA - {10'h000, irq_num, 1'b0})
        else $error("vector upper address wrong");
    tmr_lo_src_a: assert property (irq_valid && irq_num == 5'h05 |-> $past(tmr0_lo_req))
        else $error("request 5 without its source");
    tmr_hi_src_a: assert property (irq_valid && irq_num == 5'h06 |-> $past(tmr0_hi_req))
        else $error("request 6 without its source");
    wired_only_a: assert property (irq_valid |-> irq_num inside {0, 2, 5, 6, 18, 19, 20, 23})
        else $error("unwired request number won");
    // register port answers
    stat_read_a: assert property (reg_rd && reg_addr == 4'hA |=> reg_rdata == $past({irq_valid, irq_level, irq_num}))
        else $error("status read differs from outputs");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    unmapped_zero_a: assert property (reg_rd && reg_addr >= 4'hC |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // vip_props

bind vip_top vip_props i_props (.clk_sys, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .tmr0_lo_req,
    .tmr0_hi_req, .irq_valid, .irq_num, .irq_level, .vec_hi_addr, .vec_lo_addr);

/* dv/vip_core_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// core model: takes the winner take_dly clocks after a go
// ----------------------------------------------------------------
module vip_core_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // bench control
    input wire logic take_go,
    input wire logic [3:0] take_dly,
    // prioritizer side
    input wire logic irq_valid,
    output logic irq_ack
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic ack_next;
    // a late take is dropped if nothing is pending by then
    always_comb
    begin
        cnt_next = take_go ? take_dly : (cnt_reg != 4'h0) ? cnt_reg - 4'h1 : cnt_reg;
        ack_next = (cnt_reg == 4'h1) & irq_valid;
    end
    // delay counter and one-cycle ack
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt_reg <= 4'h0;
            irq_ack <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            irq_ack <= ack_next;
        end
    end
endmodule // vip_core_model

/* dv/vip_top_test.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// self-checking bench for the prioritizer
// ----------------------------------------------------------------
module vip_top_test;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic ext_irq_in_ch4 = 1'b0;
    logic ext_irq_in_ch6 = 1'b0;
    logic tmr0_lo_req = 1'b0;
    logic tmr0_hi_req = 1'b0;
    logic [3:0] slow_req = 4'h0;
    logic irq_ack, irq_valid;
    logic [4:0] irq_num;
    logic [1:0] irq_level, lv5, lv6;
    logic [15:0] vec_hi_addr, vec_lo_addr;
    logic take_go = 1'b0;
    logic [3:0] take_dly = 4'h1;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    int failures = 0;
    int n_compared = 0;
    int seed = 67431;
    always #5 clk_sys = ~clk_sys;
    vip_top i_dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ext_irq_in_ch4, .ext_irq_in_ch6, .tmr0_lo_req, .tmr0_hi_req, .adc_req(slow_req[0]),
        .tbt_req(slow_req[1]), .wpre_req(slow_req[2]), .flash_req(slow_req[3]), .irq_ack,
        .irq_valid, .irq_num, .irq_level, .vec_hi_addr, .vec_lo_addr);
    vip_core_model i_core (.clk_sys, .sys_rst, .take_go, .take_dly, .irq_valid, .irq_ack);
    // ----------------------------------------------------------------
    // bus tasks and comparison
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // the expectation is queued as the strobe goes out
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    function automatic logic [7:0] stat(input logic [1:0] l, input logic [4:0] n);
        return {1'b1, l, n};
    endfunction
    // bounded wait for a given winner
    task automatic wait_num(input logic [4:0] n);
        for (int i = 0; i < 10 && irq_num !== n; i++)
            @(posedge clk_sys);
        if (irq_num !== n)
        begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clk_sys)
    begin
        rd_seen <= reg_rd;
        if (rd_seen)
            check({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    end
    // hang guard
    initial
    begin
        idle(20000);
        failures++;
        wrap_up();
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] v;
        idle(6);
        sys_rst <= 1'b0;
        // with nothing pending the status shows the idle level 3 and number 0
        for (int k = 0; k < 16; k++)
            rd(k[3:0], (k < 6) ? vip_pkg::LVL_RST : (k == 10) ? 8'h60 :
                (k == 11) ? vip_pkg::CFG_RST : vip_pkg::EN_RST);
        wr(4'hD, 8'h5A);
        wr(vip_pkg::OFS_STAT, 8'hFF);
        rd(4'hD, 8'h00);
        rd(vip_pkg::OFS_STAT, 8'h60);
        for (int k = 0; k < 6; k++)
        begin
            v = 8'($random(seed));
            wr(k[3:0], v);
            rd(k[3:0], v);
        end
        $display("test registers done");
        // equal levels, then a better level on the higher number
        wr(4'h1, 8'hFF);
        wr(vip_pkg::OFS_EN0, 8'h60);
        tmr0_lo_req <= 1'b1;
        tmr0_hi_req <= 1'b1;
        idle(2);
        rd(vip_pkg::OFS_STAT, stat(2'h3, 5'h05));
        check(vec_hi_addr, 16'hFFF0);
        check(vec_lo_addr, 16'hFFF1);
        wr(4'h1, 8'hCF);
        idle(2);
        rd(vip_pkg::OFS_STAT, stat(2'h0, 5'h06));
        check(vec_hi_addr, 16'hFFEE);
        check(vec_lo_addr, 16'hFFEF);
        $display("test timer order done");
        // pin edges stay high far longer than two clocks
        wr(4'h0, 8'h00);
        wr(vip_pkg::OFS_EN0, 8'h65);
        ext_irq_in_ch6 <= 1'b1;
        wait_num(5'h02);
        check(vec_hi_addr, 16'hFFF6);
        check(vec_lo_addr, 16'hFFF7);
        ext_irq_in_ch4 <= 1'b1;
        wait_num(5'h00);
        check(vec_hi_addr, 16'hFFFA);
        check(vec_lo_addr, 16'hFFFB);
        rd(vip_pkg::OFS_EXT_PEND, 8'h03);
        take_go <= 1'b1;
        idle(1);
        take_go <= 1'b0;
        idle(4);
        rd(vip_pkg::OFS_STAT, stat(2'h0, 5'h02));
        take_dly <= 4'h4;
        take_go <= 1'b1;
        idle(1);
        take_go <= 1'b0;
        idle(8);
        rd(vip_pkg::OFS_STAT, stat(2'h0, 5'h06));
        // falling edge select on channel 6, then write-one-clear of its flag
        wr(vip_pkg::OFS_EXT_CFG, 8'h02);
        ext_irq_in_ch6 <= 1'b0;
        wait_num(5'h02);
        rd(vip_pkg::OFS_EXT_PEND, 8'h02);
        wr(vip_pkg::OFS_EXT_PEND, 8'h02);
        rd(vip_pkg::OFS_EXT_PEND, 8'h00);
        $display("test pins done");
        // random levels; the slow sources toggle while disabled
        for (int k = 0; k < 8; k++)
        begin
            lv5 = 2'($random(seed));
            lv6 = 2'($random(seed));
            slow_req <= 4'($random(seed));
            wr(4'h1, {2'h3, lv6, lv5, 2'h3});
            idle(2);
            rd(vip_pkg::OFS_STAT, (lv6 < lv5) ? stat(lv6, 5'h06) : stat(lv5, 5'h05));
            check({14'h0000, irq_level}, {14'h0000, (lv6 < lv5) ? lv6 : lv5});
            check({15'h0000, irq_valid}, 16'h0001);
        end
        $display("test random levels done");
        idle(3);
        wrap_up();
    end
endmodule // vip_top_test
